//--- inc/sfhp_cfg.svh
// constants for the synchronous byte fifo host port
// assumes both ends and the interface include this header
`ifndef SFHP_CFG_SVH
`define SFHP_CFG_SVH

// timing
`define SFHP_CORE_PERIOD_NS 100
`define SFHP_LINK_PERIOD_NS 1600
`define SFHP_LINK_HALF (`SFHP_LINK_PERIOD_NS / (2 * `SFHP_CORE_PERIOD_NS))
`define SFHP_DIV_W 8

// sizes
`define SFHP_FIFO_DEPTH 16
`define SFHP_BYTE_W 8

// reset and idle levels
`define SFHP_STROBES_IDLE 4'hf
`define SFHP_DEV_FLAGS_IDLE 3'h3
`define SFHP_BYTE_RST 8'h00
`define SFHP_BUS_PULL 8'hff

`endif

//--- inc/sfhp_pkg.sv
// shared types for the synchronous byte fifo host port
// assumes nothing beyond the cfg header
`default_nettype none
package sfhp_pkg;
  typedef logic [7:0] sfhp_byte_t;
  typedef enum logic [1:0] {
    hs_idle,
    hs_turn,
    hs_read,
    hs_write
  } sfhp_host_state_t;
endpackage
`default_nettype wire

//--- inc/sfhp_if.sv
// pins between the port device and the external host logic
// the shared data bus is resolved here from the two enables
`include "sfhp_cfg.svh"
`default_nettype none
interface sfhp_if;
  import sfhp_pkg::*;
  logic interface_clock_out;
  logic rx_data_available_n;
  logic tx_space_available_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic output_enable_n;
  logic send_now_wakeup_n;
  sfhp_byte_t dev_data_out;
  logic dev_data_oe;
  sfhp_byte_t host_data_out;
  logic host_data_oe;
  sfhp_byte_t fifo_data_bus;

  // an undriven bus floats high through the pull-ups
  assign fifo_data_bus = dev_data_oe ? dev_data_out :
                         host_data_oe ? host_data_out : `SFHP_BUS_PULL;

  modport dev (
    output interface_clock_out, rx_data_available_n,
    output tx_space_available_n, dev_data_out, dev_data_oe,
    input read_strobe_n, write_strobe_n, output_enable_n,
    input send_now_wakeup_n, fifo_data_bus
  );
  modport host (
    input interface_clock_out, rx_data_available_n,
    input tx_space_available_n, fifo_data_bus,
    output read_strobe_n, write_strobe_n, output_enable_n,
    output send_now_wakeup_n, host_data_out, host_data_oe
  );
endinterface
`default_nettype wire

//--- hw/sfhp_sync.sv
// three-stage pin synchroniser with a two-stage agreement filter
// assumes the input is asynchronous to core_clk
`include "sfhp_cfg.svh"
`default_nettype none
module sfhp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pin side and filtered side
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // each bit moves only once the later two stages agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/sfhp_dev.sv
// device end of the synchronous byte fifo host port
// assumes the host keeps its signals synchronous to interface_clock_out
// What this block does
// - sync mode takes over second channel resources
// - enter only with 245 config plus command
// - all transfers happen on link rising edge
// - drive data bus from a link rise that sees enable low to the next rise that sees it high
// - receive flag low means data, no reads otherwise
// - read transfer when both flags low
// - host lowers enable one period before read
// - transmit flag low means room, no writes otherwise
// - write transfer when both flags low
// - present byte, advance each cycle while reading
// - store bus byte each cycle while writing
// - device drives the link clock, host follows it
// - suspended with wakeup enabled: strobe requests resume
// - active link: strobe flushes transmit data
// - unused send-now input held high
`include "sfhp_cfg.svh"
`default_nettype none
module sfhp_dev
  import sfhp_pkg::*;
#(
  parameter int DEPTH = `SFHP_FIFO_DEPTH,
  parameter int HALF = `SFHP_LINK_HALF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link pins
  sfhp_if.dev lnk,
  // mode selection
  input wire logic cfg_port_245,
  input wire logic bitmode_cmd,
  input wire logic bitmode_sync_fifo,
  output logic mode_active,
  output logic channel_b_available,
  // bytes arriving from usb for the host
  input wire logic rx_push,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // bytes from the host leaving toward usb
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_taken,
  // send immediate and wakeup
  input wire logic usb_configured_indicator_n,
  input wire logic remote_wakeup_en,
  output logic resume_req,
  output logic flush_req
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int DW = `SFHP_DIV_W;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] c,
                                             input logic up,
                                             input logic dn);
    cnt_next = c + CW'(up) - CW'(dn);
  endfunction

  // link clock divider; the link side needs no second domain
  logic [DW-1:0] div_cnt;
  logic rise_tick;
  assign rise_tick = (div_cnt == DW'(HALF - 1)) && !lnk.interface_clock_out;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= '0;
      lnk.interface_clock_out <= 1'b0;
    end else if (div_cnt == DW'(HALF - 1)) begin
      div_cnt <= '0;
      lnk.interface_clock_out <= !lnk.interface_clock_out;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // host strobes and bus come from outside the clock domain
  logic [3:0] strb;
  sfhp_byte_t bus_s;
  logic rd_s;
  logic wr_s;
  logic oe_s;
  logic send_now_wakeup_n_s;
  assign {send_now_wakeup_n_s, oe_s, wr_s, rd_s} = strb;

  sfhp_sync #(.W(4), .INIT(`SFHP_STROBES_IDLE)) u_strb (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin({lnk.send_now_wakeup_n, lnk.output_enable_n,
          lnk.write_strobe_n, lnk.read_strobe_n}),
    .level(strb)
  );

  sfhp_sync #(.W(8), .INIT(`SFHP_BYTE_RST)) u_bus (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(lnk.fifo_data_bus),
    .level(bus_s)
  );

  // mode entry needs both the stored config and the command
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_active <= 1'b0;
      channel_b_available <= 1'b1;
    end else if (bitmode_cmd) begin
      mode_active <= cfg_port_245 && bitmode_sync_fifo;
      channel_b_available <= !(cfg_port_245 && bitmode_sync_fifo);
    end
  end

  // receive fifo
  sfhp_byte_t rx_mem [DEPTH];
  logic [AW-1:0] rx_wp;
  logic [AW-1:0] rx_rp;
  logic [CW-1:0] rx_cnt;
  logic rx_in;
  logic rx_out;
  logic [CW-1:0] next_rx_cnt;
  logic [AW-1:0] next_rx_rp;

  assign rx_in = rx_push && rx_ready;
  assign rx_out = rise_tick && mode_active && !rd_s &&
                  !lnk.rx_data_available_n;
  assign next_rx_cnt = cnt_next(rx_cnt, rx_in, rx_out);
  assign next_rx_rp = rx_out ? ptr_inc(rx_rp) : rx_rp;

  always_ff @(posedge core_clk) begin
    if (rx_in) begin
      rx_mem[rx_wp] <= rx_byte;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_ready <= 1'b1;
    end else begin
      if (rx_in) begin
        rx_wp <= ptr_inc(rx_wp);
      end
      rx_rp <= next_rx_rp;
      rx_cnt <= next_rx_cnt;
      rx_ready <= next_rx_cnt != CW'(DEPTH);
    end
  end

  // flag and byte move only on the link rising edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.rx_data_available_n <= 1'b1;
      lnk.dev_data_out <= `SFHP_BYTE_RST;
      lnk.dev_data_oe <= 1'b0;
    end else if (rise_tick) begin
      // flag rises at the very edge that takes the last byte
      lnk.rx_data_available_n <= !(mode_active &&
                                   next_rx_cnt != '0);
      // bypass covers a byte written in this same cycle
      if (rx_in && rx_wp == next_rx_rp) begin
        lnk.dev_data_out <= rx_byte;
      end else begin
        lnk.dev_data_out <= rx_mem[next_rx_rp];
      end
      lnk.dev_data_oe <= mode_active && !oe_s;
    end
  end

  // transmit fifo
  sfhp_byte_t tx_mem [DEPTH];
  logic [AW-1:0] tx_wp;
  logic [AW-1:0] tx_rp;
  logic [CW-1:0] tx_cnt;
  logic tx_in;
  logic tx_out;
  logic [CW-1:0] next_tx_cnt;

  assign tx_in = rise_tick && mode_active && !wr_s &&
                 !lnk.tx_space_available_n;
  assign tx_out = (tx_cnt != '0) && (!tx_valid || tx_taken);
  assign next_tx_cnt = cnt_next(tx_cnt, tx_in, tx_out);

  always_ff @(posedge core_clk) begin
    if (tx_in) begin
      tx_mem[tx_wp] <= bus_s;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_in) begin
        tx_wp <= ptr_inc(tx_wp);
      end
      if (tx_out) begin
        tx_rp <= ptr_inc(tx_rp);
      end
      tx_cnt <= next_tx_cnt;
    end
  end

  // output stage toward usb
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_byte <= `SFHP_BYTE_RST;
    end else if (tx_out) begin
      tx_valid <= 1'b1;
      tx_byte <= tx_mem[tx_rp];
    end else if (tx_taken) begin
      tx_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.tx_space_available_n <= 1'b1;
    end else if (rise_tick) begin
      lnk.tx_space_available_n <= !(mode_active &&
                                    next_tx_cnt != CW'(DEPTH));
    end
  end

  // send-now strobe, seen as a falling level at a link edge
  logic send_now_wakeup_n_q;
  logic send_now_wakeup_n_fall;
  assign send_now_wakeup_n_fall = rise_tick && send_now_wakeup_n_q && !send_now_wakeup_n_s;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      send_now_wakeup_n_q <= 1'b1;
      resume_req <= 1'b0;
      flush_req <= 1'b0;
    end else begin
      if (rise_tick) begin
        send_now_wakeup_n_q <= send_now_wakeup_n_s;
      end
      // a held-high input never fires either request
      resume_req <= send_now_wakeup_n_fall && mode_active &&
                    usb_configured_indicator_n && remote_wakeup_en;
      flush_req <= send_now_wakeup_n_fall && mode_active &&
                   !usb_configured_indicator_n;
    end
  end
endmodule
`default_nettype wire

//--- hw/sfhp_host.sv
// external host end of the synchronous byte fifo host port
// assumes the device drives the link clock and both flags
`include "sfhp_cfg.svh"
`default_nettype none
module sfhp_host
  import sfhp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link pins
  sfhp_if.host lnk,
  // read side
  input wire logic rd_en,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  // write side
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  output logic wr_ack,
  // send now request, one cycle
  input wire logic send_now_req
);
  logic [2:0] flg;
  sfhp_byte_t bus_s;
  logic clk_s;
  logic txe_s;
  logic rxf_s;
  assign {clk_s, txe_s, rxf_s} = flg;

  sfhp_sync #(.W(3), .INIT(`SFHP_DEV_FLAGS_IDLE)) u_flg (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin({lnk.interface_clock_out, lnk.tx_space_available_n,
          lnk.rx_data_available_n}),
    .level(flg)
  );

  sfhp_sync #(.W(8), .INIT(`SFHP_BYTE_RST)) u_bus (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(lnk.fifo_data_bus),
    .level(bus_s)
  );

  // link edges; values caught at the fall are those the next rise uses
  logic clk_q;
  logic rise;
  logic fall;
  logic rxf_f;
  logic txe_f;
  assign rise = clk_s && !clk_q;
  assign fall = !clk_s && clk_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_q <= 1'b0;
      rxf_f <= 1'b1;
      txe_f <= 1'b1;
    end else begin
      clk_q <= clk_s;
      if (fall) begin
        rxf_f <= rxf_s;
        txe_f <= txe_s;
      end
    end
  end

  sfhp_host_state_t st;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_byte <= `SFHP_BYTE_RST;
    end else begin
      rd_valid <= fall && st == hs_read && !lnk.read_strobe_n &&
                  !rxf_s;
      if (fall && st == hs_read) begin
        rd_byte <= bus_s;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= hs_idle;
      lnk.read_strobe_n <= 1'b1;
      lnk.write_strobe_n <= 1'b1;
      lnk.output_enable_n <= 1'b1;
      lnk.host_data_oe <= 1'b0;
      lnk.host_data_out <= `SFHP_BYTE_RST;
      wr_ack <= 1'b0;
    end else begin
      wr_ack <= 1'b0;
      if (rise) begin
        unique case (st)
          hs_idle: begin
            if (rd_en && !rxf_f) begin
              lnk.output_enable_n <= 1'b0;
              st <= hs_turn;
            end else if (wr_valid && !txe_f) begin
              lnk.write_strobe_n <= 1'b0;
              lnk.host_data_oe <= 1'b1;
              lnk.host_data_out <= wr_byte;
              st <= hs_write;
            end
          end
          hs_turn: begin
            // a whole link period of enable before the read strobe
            lnk.read_strobe_n <= 1'b0;
            st <= hs_read;
          end
          hs_read: begin
            if (rxf_f || !rd_en) begin
              lnk.read_strobe_n <= 1'b1;
              lnk.output_enable_n <= 1'b1;
              st <= hs_idle;
            end
          end
          hs_write: begin
            if (!txe_f) begin
              wr_ack <= 1'b1;
              lnk.write_strobe_n <= 1'b1;
              lnk.host_data_oe <= 1'b0;
              st <= hs_idle;
            end
          end
        endcase
      end
    end
  end

  // send-now: one link period low per request, idle high otherwise
  logic send_now_wakeup_n_pend;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      send_now_wakeup_n_pend <= 1'b0;
      lnk.send_now_wakeup_n <= 1'b1;
    end else begin
      if (send_now_req) begin
        send_now_wakeup_n_pend <= 1'b1;
      end else if (rise && lnk.send_now_wakeup_n) begin
        send_now_wakeup_n_pend <= 1'b0;
      end
      if (rise) begin
        lnk.send_now_wakeup_n <= !(send_now_wakeup_n_pend && lnk.send_now_wakeup_n);
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/sfhp_assertions.sv
// link-level checker for the synchronous byte fifo host port
// assumes the bench instantiates it beside the interface, on core_clk
`default_nettype none
module sfhp_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // device driven pins
  input wire logic interface_clock_out,
  input wire logic rx_data_available_n,
  input wire logic tx_space_available_n,
  input wire logic dev_data_oe,
  // host driven pins
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic send_now_wakeup_n,
  input wire logic host_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] oe_high_cnt;

  // saturates so a long idle spell cannot wrap back below the limit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_high_cnt <= 6'h00;
    end else if (!output_enable_n) begin
      oe_high_cnt <= 6'h00;
    end else if (oe_high_cnt != 6'h3f) begin
      oe_high_cnt <= oe_high_cnt + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_link_high;
    $rose(interface_clock_out) |=>
      interface_clock_out [*7] ##1 !interface_clock_out;
  endproperty
  a_link_high: assert property (p_link_high)
    else $error("link clock high phase has the wrong length");

  property p_link_low;
    $fell(interface_clock_out) |=>
      !interface_clock_out [*7] ##1 interface_clock_out;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("link clock low phase has the wrong length");

  property p_rx_flag_rise;
    $changed(rx_data_available_n) |-> interface_clock_out;
  endproperty
  a_rx_flag_rise: assert property (p_rx_flag_rise)
    else $error("receive flag moved away from a link rise");

  property p_tx_flag_rise;
    $changed(tx_space_available_n) |-> interface_clock_out;
  endproperty
  a_tx_flag_rise: assert property (p_tx_flag_rise)
    else $error("transmit flag moved away from a link rise");

  property p_drive_needs_enable;
    $rose(dev_data_oe) |-> !output_enable_n;
  endproperty
  a_drive_needs_enable: assert property (p_drive_needs_enable)
    else $error("device drove the bus without the enable");

  property p_release_bus;
    oe_high_cnt >= 6'h18 |-> !dev_data_oe;
  endproperty
  a_release_bus: assert property (p_release_bus)
    else $error("device kept driving after the enable went high");

  property p_enable_before_read;
    $fell(read_strobe_n) |->
      !output_enable_n && !$past(output_enable_n, 15);
  endproperty
  a_enable_before_read: assert property (p_enable_before_read)
    else $error("read strobe came too soon after the enable");

  property p_write_drives_bus;
    !write_strobe_n |-> host_data_oe;
  endproperty
  a_write_drives_bus: assert property (p_write_drives_bus)
    else $error("write strobe low while the host left the bus");

  property p_strobe_sync;
    $changed(read_strobe_n) || $changed(write_strobe_n) |->
      interface_clock_out;
  endproperty
  a_strobe_sync: assert property (p_strobe_sync)
    else $error("host strobe moved in the link clock low phase");

  property p_wake_width;
    $fell(send_now_wakeup_n) |->
      !send_now_wakeup_n [*8] ##[1:12] send_now_wakeup_n;
  endproperty
  a_wake_width: assert property (p_wake_width)
    else $error("send now strobe is not one link period long");

  c_read: cover property ($fell(read_strobe_n));
  c_write: cover property ($fell(write_strobe_n));
  c_rx_empty: cover property ($rose(rx_data_available_n));
  c_wake: cover property ($fell(send_now_wakeup_n));
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench joining the device end and the host end
// assumes the package, interface and both ends are compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, cfg_port_245, bitmode_cmd, bitmode_sync_fifo;
  logic mode_active, channel_b_available, rx_push, rx_ready, tx_valid;
  logic tx_taken, rd_en, rd_valid, wr_valid, wr_ack, send_now_req, drain;
  logic usb_configured_indicator_n, remote_wakeup_en, resume_req, flush_req;
  logic [7:0] rx_byte, tx_byte, rd_byte, wr_byte;
  logic [31:0] seed;
  logic [7:0] rxq[$], txq[$];
  int num_errors, cmp_count, n_flush, n_resume, i;

  sfhp_if lnk_if();
  sfhp_dev i_sfhp_dev (.core_clk(core_clk), .sys_rst(sys_rst),
    .lnk(lnk_if), .cfg_port_245(cfg_port_245), .bitmode_cmd(bitmode_cmd),
    .bitmode_sync_fifo(bitmode_sync_fifo), .mode_active(mode_active),
    .channel_b_available(channel_b_available), .rx_push(rx_push),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_taken(tx_taken),
    .usb_configured_indicator_n(usb_configured_indicator_n),
    .remote_wakeup_en(remote_wakeup_en), .resume_req(resume_req),
    .flush_req(flush_req));
  sfhp_host i_sfhp_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .lnk(lnk_if), .rd_en(rd_en), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ack(wr_ack),
    .send_now_req(send_now_req));
  sfhp_assertions i_sfhp_assertions (.core_clk(core_clk),
    .sys_rst(sys_rst), .interface_clock_out(lnk_if.interface_clock_out),
    .rx_data_available_n(lnk_if.rx_data_available_n),
    .tx_space_available_n(lnk_if.tx_space_available_n),
    .dev_data_oe(lnk_if.dev_data_oe), .read_strobe_n(lnk_if.read_strobe_n),
    .write_strobe_n(lnk_if.write_strobe_n),
    .output_enable_n(lnk_if.output_enable_n),
    .send_now_wakeup_n(lnk_if.send_now_wakeup_n),
    .host_data_oe(lnk_if.host_data_oe));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // while draining, the usb side takes bytes at random cycles
  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (drain) begin
        seed = xs(seed);
        tx_taken = seed[0];
      end
    end
  endtask

  task automatic mode_cmd(input logic cfg, input logic sel);
    cfg_port_245 = cfg;
    bitmode_sync_fifo = sel;
    bitmode_cmd = 1'b1;
    step(1);
    bitmode_cmd = 1'b0;
    step(2);
  endtask

  // strobe is held through the edge that samples the acknowledge
  task automatic host_write();
    int j;
    step(1);
    seed = xs(seed);
    wr_byte = seed[7:0];
    wr_valid = 1'b1;
    txq.push_back(seed[7:0]);
    for (j = 0; j < 2000 && wr_ack !== 1'b1; j++) step(1);
    step(1);
    wr_valid = 1'b0;
  endtask

  // outputs are read before this edge's updates land
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (rxq.size() == 0) check("rd_extra", 1, 0);
      else check("rd_byte", rd_byte, rxq.pop_front());
    end
    if (tx_valid === 1'b1 && tx_taken === 1'b1) begin
      if (txq.size() == 0) check("tx_extra", 1, 0);
      else check("tx_byte", tx_byte, txq.pop_front());
    end
    if (flush_req === 1'b1) n_flush++;
    if (resume_req === 1'b1) n_resume++;
  end

  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {cfg_port_245, bitmode_cmd, bitmode_sync_fifo, rx_push, rd_en} = 5'h00;
    {tx_taken, wr_valid, send_now_req, drain, remote_wakeup_en} = 5'h00;
    {rx_byte, wr_byte} = 16'h0000;
    usb_configured_indicator_n = 1'b0;
    seed = 32'h5b3c;
    sys_rst = 1'b1;
    step(8);
    sys_rst = 1'b0;
    step(20);
    check("rx_flag_idle", lnk_if.rx_data_available_n, 1);
    check("tx_flag_idle", lnk_if.tx_space_available_n, 1);
    check("dev_oe_idle", lnk_if.dev_data_oe, 0);
    check("send_now_wakeup_n_idle", lnk_if.send_now_wakeup_n, 1);
    for (i = 0; i < 4; i++) begin
      mode_cmd(i[0], i[1]);
      check("mode", mode_active, i == 3);
      check("chan_b", channel_b_available, i != 3);
    end
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      rx_byte = seed[7:0];
      rx_push = 1'b1;
      rxq.push_back(seed[7:0]);
      step(1);
    end
    rx_push = 1'b0;
    step(1);
    check("rx_full", rx_ready, 0);
    // refused push: a stored byte would show up as an extra read
    rx_byte = 8'hff;
    rx_push = 1'b1;
    step(1);
    rx_push = 1'b0;
    step(40);
    check("rx_flag_data", lnk_if.rx_data_available_n, 0);
    rd_en = 1'b1;
    for (i = 0; i < 3000 && rxq.size() > 0; i++) step(1);
    step(64);
    rd_en = 1'b0;
    check("rx_left", rxq.size(), 0);
    check("rx_flag_empty", lnk_if.rx_data_available_n, 1);
    // one byte more than the fifo: the usb output stage holds one
    for (i = 0; i < 17; i++) host_write();
    step(64);
    check("tx_flag_full", lnk_if.tx_space_available_n, 1);
    drain = 1'b1;
    for (i = 0; i < 8; i++) host_write();
    for (i = 0; i < 3000 && txq.size() > 0; i++) step(1);
    check("tx_left", txq.size(), 0);
    for (i = 0; i < 3; i++) begin
      usb_configured_indicator_n = (i != 0);
      remote_wakeup_en = (i == 1);
      n_flush = 0;
      n_resume = 0;
      send_now_req = 1'b1;
      step(1);
      send_now_req = 1'b0;
      step(80);
      check("flush", n_flush, i == 0);
      check("resume", n_resume, i == 1);
    end
    mode_cmd(1'b0, 1'b1);
    check("mode_clr", mode_active, 0);
    mode_cmd(1'b1, 1'b1);
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    step(2);
    check("mode_rst", mode_active, 0);
    check("chan_b_rst", channel_b_available, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
